// file: rtl/sirq_pkg.sv
package sirq_pkg;
	// register offsets (byte-wide port, printed addresses)
	localparam logic [3:0] ADDR_STATUS   = 4'h4;
	localparam logic [3:0] ADDR_DEST_ID  = 4'h4;
	localparam logic [3:0] ADDR_CAUSE    = 4'h5;
	localparam logic [3:0] ADDR_TIMEOUT  = 4'h5;
	localparam logic [3:0] ADDR_SYNC_PER = 4'h6;
	localparam logic [3:0] ADDR_SEQ_STEP = 4'h6;
	localparam logic [3:0] ADDR_CTRL     = 4'h8;
	localparam logic [3:0] ADDR_COMMAND  = 4'h3;

	localparam logic [4:0] SYNC_PER_RST  = 5'h05;
	localparam logic [5:0] SYNC_MIN_CLKS = 6'h05;
	localparam logic [5:0] SYNC_WRAP     = 6'h20;
	localparam int         TIMEOUT_UNIT  = 8192;
	localparam logic [6:0] CMD_EXEMPT    = 7'h07;

	// interrupt cause bit positions
	localparam int C_BUS_RST = 7;
	localparam int C_BAD_CMD = 6;
	localparam int C_DISC    = 5;
	localparam int C_BUS_SVC = 4;
	localparam int C_FUNC    = 3;
	localparam int C_RESELECTED_FLAG   = 2;
	localparam int C_SELECTED_ATTN_FLAG = 1;
	localparam int C_SEL     = 0;

	// control register bits
	localparam int CTRL_SCSI2 = 0;
	localparam int CTRL_SWRST = 1;

	typedef enum logic [1:0] {SIRQ_DISC, SIRQ_INIT, SIRQ_TARG} sirq_mode_t;

	// one complete interrupt report: status latched bits, step, cause
	typedef struct packed {
		logic       valid_group_flag;
		logic [2:0] step;
		logic [7:0] cause;
	} sirq_report_t;

	// events reported by the sequencer core
	typedef struct packed {
		logic       bus_rst;
		logic       cmd_taken;
		logic [6:0] cmd_code;
		logic       sel_target;
		logic       sel_attn;
		logic       reselected;
		logic       target_disc;
		logic       cmd_done;
		logic       attn_seen;
		logic       req_seen;
		logic       msg_in_req;
		logic       sel_done;
		logic       step_inc;
		logic       cdb_first;
		logic [7:0] cdb_byte;
	} sirq_evt_t;
endpackage : sirq_pkg

// file: rtl/sirq_regs.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// What this block does
// R1 - when selected, decode CDB group code; set valid-group flag only for defined groups
// R2 - SCSI-2 bit set makes group 2 ten-byte valid, else reserved
// R3 - groups 3 and 4 reserved; reserved groups request 6 bytes, flag clear
// R4 - group 6 six-byte, group 7 ten-byte vendor-unique commands
// R5 - valid-group flag cleared by cause read with irq up, or chip reset
// R6 - phase status bits are live bus phase lines, never latched
// R7 - initiator phase interrupt raised only after target asserts REQ
// R8 - destination low three bits binary ID, driven one-hot on bus
// R9 - target_bus_id untouched by any reset
// R10 - cause read with irq active clears cause, status latched bits and step
// R11 - chip reset clears cause register; bus reset leaves it
// R12 - bus reset always sets bus-reset cause bit
// R13 - unused code or wrong-mode command sets bad-command bit; code 7 exempt
// R14 - disconnect bit on target disconnect or selection timeout
// R15 - bus-service on ATN as target, info-phase request as initiator
// R16 - function-done on target command end, or initiator select/complete/msg-in
// R17 - bus-initiated selection sets exactly one of reselected, sel-attn, sel
// R18 - timeout register times 8192 clocks; arbitration retries forever; reset-proof
// R19 - sync period: codes 4,5 give 5, 0..3 give 32..35, else own value
// R20 - sync period returns to 5 on chip reset, not bus reset
// R21 - three-bit sequence step advances at sequence points
// R22 - selection timeout reports step 000, only disconnect bit
// R23 - cause read or chip reset releases irq and status irq flag
// R24 - second interrupt queued and presented after first is serviced
module sirq_regs (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic [3:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [7:0]              reg_rdata,
	input  wire logic [2:0]         bus_phase,
	input  wire sirq_pkg::sirq_evt_t evt,
	input  wire logic               arb_won,
	input  wire logic               sel_start,
	output logic                    irq,
	output logic [7:0]              target_id_onehot,
	output logic                    sel_timed_out,
	output logic [5:0]              sync_clks,
	output logic                    byte_tick,
	output logic [3:0]              cdb_len,
	output logic                    chip_reset
);
	sirq_pkg::sirq_report_t cur_r;
	sirq_pkg::sirq_report_t pend_r;
	sirq_pkg::sirq_report_t rep_nxt;
	sirq_pkg::sirq_mode_t   mode_r;
	logic        cur_v_r;
	logic        pend_v_r;
	logic [7:0]  ctrl_r;
	logic [2:0]  dest_r;
	logic [7:0]  timeout_r;
	logic [4:0]  sync_r;
	logic [20:0] to_cnt_r;
	logic        to_run_r;
	logic [5:0]  tick_cnt_r;
	logic        swrst_r;
	logic        new_ev;
	logic        serviced;
	logic        timeout_hit;
	logic        bad_cmd;
	logic        grp_valid;

	function automatic logic [5:0] sirq_period(input logic [4:0] code);
		if (code[4:2] == 3'h0)
			sirq_period = sirq_pkg::SYNC_WRAP + {4'h0, code[1:0]}; // R19
		else if (code <= sirq_pkg::SYNC_PER_RST)
			sirq_period = sirq_pkg::SYNC_MIN_CLKS; // R19
		else
			sirq_period = {1'b0, code}; // R19
	endfunction : sirq_period

	function automatic logic sirq_grp_valid(input logic [2:0] grp, input logic scsi2);
		case (grp)
			3'h0, 3'h1, 3'h5, 3'h6, 3'h7: sirq_grp_valid = 1'b1; // R1 R4
			3'h2: sirq_grp_valid = scsi2; // R2
			default: sirq_grp_valid = 1'b0; // R3
		endcase
	endfunction : sirq_grp_valid

	function automatic logic [3:0] sirq_grp_len(input logic [2:0] grp, input logic scsi2);
		case (grp)
			3'h1, 3'h7: sirq_grp_len = 4'hA; // R4
			3'h2: sirq_grp_len = scsi2 ? 4'hA : 4'h6; // R2
			3'h5: sirq_grp_len = 4'hC;
			default: sirq_grp_len = 4'h6; // R3 R4
		endcase
	endfunction : sirq_grp_len

	// unused codes and mode mismatch; group in bits 6..4, 0 = misc
	function automatic logic sirq_cmd_bad(input logic [6:0] c, input sirq_pkg::sirq_mode_t m);
		if (c == sirq_pkg::CMD_EXEMPT)
			sirq_cmd_bad = 1'b0; // R13
		else case (c[6:4])
			3'h0: sirq_cmd_bad = (c[3:0] > 4'h3);
			3'h1: sirq_cmd_bad = (m != sirq_pkg::SIRQ_INIT) || (c[3:0] == 4'hF);
			3'h2: sirq_cmd_bad = (m != sirq_pkg::SIRQ_TARG) || (c[3:0] > 4'hB);
			3'h4: sirq_cmd_bad = (m != sirq_pkg::SIRQ_DISC) || (c[3:0] > 4'h6);
			default: sirq_cmd_bad = 1'b1; // R13
		endcase
	endfunction : sirq_cmd_bad

	assign grp_valid   = sirq_grp_valid(evt.cdb_byte[7:5], ctrl_r[sirq_pkg::CTRL_SCSI2]);
	assign bad_cmd     = evt.cmd_taken && sirq_cmd_bad(evt.cmd_code, mode_r);
	assign timeout_hit = to_run_r && (to_cnt_r == 21'h0_0001);
	assign serviced    = reg_rd && (reg_addr == sirq_pkg::ADDR_CAUSE) && irq; // R10 R23

	// cause bits produced this cycle
	always_comb begin
		rep_nxt = '0;
		rep_nxt.cause[sirq_pkg::C_BUS_RST] = evt.bus_rst; // R12
		rep_nxt.cause[sirq_pkg::C_BAD_CMD] = bad_cmd; // R13
		rep_nxt.cause[sirq_pkg::C_DISC] = evt.target_disc || timeout_hit; // R14 R22
		rep_nxt.cause[sirq_pkg::C_BUS_SVC] = (mode_r == sirq_pkg::SIRQ_TARG && evt.attn_seen)
			|| (mode_r == sirq_pkg::SIRQ_INIT && evt.req_seen); // R15 R7
		rep_nxt.cause[sirq_pkg::C_FUNC] = evt.cmd_done || evt.sel_done
			|| (mode_r == sirq_pkg::SIRQ_INIT && evt.msg_in_req && evt.req_seen); // R16 R7
		if (evt.reselected)
			rep_nxt.cause[sirq_pkg::C_RESELECTED_FLAG] = 1'b1; // R17
		else if (evt.sel_target && evt.sel_attn)
			rep_nxt.cause[sirq_pkg::C_SELECTED_ATTN_FLAG] = 1'b1; // R17
		else if (evt.sel_target)
			rep_nxt.cause[sirq_pkg::C_SEL] = 1'b1; // R17
		rep_nxt.valid_group_flag = evt.cdb_first && grp_valid; // R1
	end
	assign new_ev = |rep_nxt.cause;

	// software reset pulse from the control register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			swrst_r <= 1'b0;
		else
			swrst_r <= reg_wr && (reg_addr == sirq_pkg::ADDR_CTRL) && reg_wdata[sirq_pkg::CTRL_SWRST];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			ctrl_r <= 8'h00;
		else if (reg_wr && reg_addr == sirq_pkg::ADDR_CTRL)
			ctrl_r <= {7'h00, reg_wdata[sirq_pkg::CTRL_SCSI2]};
	end

	// no reset: these keep their value through every reset
	always_ff @(posedge sys_clk) begin
		if (reg_wr && reg_addr == sirq_pkg::ADDR_DEST_ID)
			dest_r <= reg_wdata[2:0]; // R8 R9
		if (reg_wr && reg_addr == sirq_pkg::ADDR_TIMEOUT)
			timeout_r <= reg_wdata; // R18
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			sync_r <= sirq_pkg::SYNC_PER_RST; // R20
		else if (swrst_r)
			sync_r <= sirq_pkg::SYNC_PER_RST; // R20
		else if (reg_wr && reg_addr == sirq_pkg::ADDR_SYNC_PER)
			sync_r <= reg_wdata[4:0];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			mode_r <= sirq_pkg::SIRQ_DISC;
		else if (swrst_r || evt.target_disc || timeout_hit)
			mode_r <= sirq_pkg::SIRQ_DISC;
		else if (evt.reselected || sel_start)
			mode_r <= sirq_pkg::SIRQ_INIT;
		else if (evt.sel_target)
			mode_r <= sirq_pkg::SIRQ_TARG;
	end

	// response wait starts only once arbitration is won; losing retries with no limit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			to_run_r <= 1'b0;
			to_cnt_r <= 21'h0_0000;
		end else if (swrst_r || evt.sel_done || evt.reselected) begin
			to_run_r <= 1'b0;
		end else if (arb_won) begin
			to_run_r <= (timeout_r != 8'h00); // R18
			to_cnt_r <= 21'(timeout_r * sirq_pkg::TIMEOUT_UNIT); // R18
		end else if (to_run_r) begin
			to_cnt_r <= to_cnt_r - 21'h0_0001;
			if (timeout_hit)
				to_run_r <= 1'b0;
		end
	end

	// current report and one queued behind it; an event while busy goes to the queue
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur_r    <= '0; // R11
			pend_r   <= '0;
			cur_v_r  <= 1'b0;
			pend_v_r <= 1'b0;
		end else if (swrst_r) begin
			cur_r    <= '0; // R11 R5
			pend_r   <= '0;
			cur_v_r  <= 1'b0;
			pend_v_r <= 1'b0;
		end else if (serviced) begin
			if (pend_v_r) begin
				cur_r    <= pend_r; // R24
				cur_v_r  <= 1'b1;
				pend_v_r <= new_ev;
				pend_r   <= rep_nxt;
			end else begin
				cur_r   <= new_ev ? rep_nxt : '0; // R10 R5
				cur_v_r <= new_ev;
			end
		end else if (new_ev && cur_v_r) begin
			pend_r.cause <= pend_r.cause | rep_nxt.cause; // R24
			pend_r.valid_group_flag   <= pend_r.valid_group_flag | rep_nxt.valid_group_flag;
			pend_v_r     <= 1'b1;
			if (timeout_hit)
				pend_r.step <= 3'h0; // R22
		end else begin
			cur_r.cause <= cur_r.cause | rep_nxt.cause;
			cur_r.valid_group_flag   <= cur_r.valid_group_flag | rep_nxt.valid_group_flag; // R1
			if (timeout_hit)
				cur_r.step <= 3'h0; // R22
			else if (evt.step_inc)
				cur_r.step <= cur_r.step + 3'h1; // R21
			cur_v_r <= new_ev || cur_v_r;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else if (swrst_r || serviced)
			irq <= 1'b0; // R23
		else if (cur_v_r)
			irq <= 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				sirq_pkg::ADDR_STATUS:   reg_rdata <= {irq, 3'h0, cur_r.valid_group_flag, bus_phase}; // R6
				sirq_pkg::ADDR_CAUSE:    reg_rdata <= cur_r.cause;
				sirq_pkg::ADDR_SEQ_STEP: reg_rdata <= {5'h00, cur_r.step};
				sirq_pkg::ADDR_CTRL:     reg_rdata <= ctrl_r;
				default:                 reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			tick_cnt_r <= 6'h01;
		else if (tick_cnt_r >= sirq_period(sync_r))
			tick_cnt_r <= 6'h01;
		else
			tick_cnt_r <= tick_cnt_r + 6'h01;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			target_id_onehot <= 8'h00;
			sel_timed_out    <= 1'b0;
			sync_clks        <= sirq_pkg::SYNC_MIN_CLKS;
			byte_tick        <= 1'b0;
			cdb_len          <= 4'h6;
			chip_reset       <= 1'b0;
		end else begin
			target_id_onehot <= 8'h01 << dest_r; // R8
			sel_timed_out    <= timeout_hit;
			sync_clks        <= sirq_period(sync_r); // R19
			byte_tick        <= (tick_cnt_r >= sirq_period(sync_r)); // R19
			chip_reset       <= swrst_r;
			if (evt.cdb_first)
				cdb_len <= sirq_grp_len(evt.cdb_byte[7:5], ctrl_r[sirq_pkg::CTRL_SCSI2]); // R3
		end
	end

	a_bus_rst_cause: assert property (@(posedge sys_clk) disable iff (rst) // R12
		evt.bus_rst && !swrst_r && !serviced && !cur_v_r |=> cur_r.cause[sirq_pkg::C_BUS_RST])
		else $error("bus reset not reported");
	a_service_clears: assert property (@(posedge sys_clk) disable iff (rst) // R10
		serviced && !pend_v_r && !new_ev |=> cur_r == '0)
		else $error("service read did not clear report");
	a_irq_release: assert property (@(posedge sys_clk) disable iff (rst) // R23
		serviced |=> !irq)
		else $error("irq not released by cause read");
	a_swrst_clears: assert property (@(posedge sys_clk) disable iff (rst) // R11
		swrst_r |=> cur_r.cause == 8'h00 && !irq && sync_r == sirq_pkg::SYNC_PER_RST)
		else $error("chip reset left state");
	a_sel_onehot: assert property (@(posedge sys_clk) disable iff (rst) // R17
		(evt.sel_target || evt.reselected) && !cur_v_r && !swrst_r && !serviced
		|=> $onehot(cur_r.cause[2:0]))
		else $error("selection cause not exactly one bit");
	a_timeout_step: assert property (@(posedge sys_clk) disable iff (rst) // R22
		timeout_hit && !cur_v_r && !swrst_r && !serviced && !evt.bus_rst && !bad_cmd
		|=> cur_r.step == 3'h0 && cur_r.cause[sirq_pkg::C_DISC])
		else $error("timeout report wrong");
	a_exempt_cmd: assert property (@(posedge sys_clk) disable iff (rst) // R13
		evt.cmd_taken && evt.cmd_code == sirq_pkg::CMD_EXEMPT |-> !bad_cmd)
		else $error("exempt command flagged");
	a_grp_reserved: assert property (@(posedge sys_clk) disable iff (rst) // R3
		evt.cdb_first && evt.cdb_byte[7:5] inside {3'h3, 3'h4}
		|-> !rep_nxt.valid_group_flag ##1 cdb_len == 4'h6)
		else $error("reserved group mishandled");
	// destination is unknown until first written, so only check after a write
	a_onehot_id: assert property (@(posedge sys_clk) disable iff (rst) // R8
		reg_wr && reg_addr == sirq_pkg::ADDR_DEST_ID
		|-> ##2 $onehot(target_id_onehot) && target_id_onehot[$past(dest_r)])
		else $error("target_bus_id not one-hot");
	a_period_min: assert property (@(posedge sys_clk) disable iff (rst) // R19
		$past(sync_r) == 5'h04 |-> sync_clks == 6'h05)
		else $error("period code 4 not five clocks");
	a_period_wrap: assert property (@(posedge sys_clk) disable iff (rst) // R19
		$past(sync_r) == 5'h00 |-> sync_clks == 6'h20)
		else $error("period code 0 not thirty-two clocks");
	a_bus_rst_keep: assert property (@(posedge sys_clk) disable iff (rst) // R20
		evt.bus_rst && !swrst_r && !(reg_wr && reg_addr == sirq_pkg::ADDR_SYNC_PER)
		|=> sync_r == $past(sync_r))
		else $error("bus reset changed sync period");
	a_timeout_pulse: assert property (@(posedge sys_clk) disable iff (rst) // R18
		timeout_hit |=> sel_timed_out && mode_r == sirq_pkg::SIRQ_DISC)
		else $error("timeout did not disconnect");
	a_phase_live: assert property (@(posedge sys_clk) disable iff (rst) // R6
		reg_rd && reg_addr == sirq_pkg::ADDR_STATUS |=> reg_rdata[2:0] == $past(bus_phase))
		else $error("phase bits not live");
	a_group2_ten: assert property (@(posedge sys_clk) disable iff (rst) // R2
		evt.cdb_first && evt.cdb_byte[7:5] == 3'h2 && ctrl_r[sirq_pkg::CTRL_SCSI2]
		|-> rep_nxt.valid_group_flag ##1 cdb_len == 4'hA)
		else $error("group 2 not ten-byte valid");
	a_vendor_six: assert property (@(posedge sys_clk) disable iff (rst) // R4
		evt.cdb_first && evt.cdb_byte[7:5] == 3'h6 |-> rep_nxt.valid_group_flag ##1 cdb_len == 4'h6)
		else $error("group 6 not six bytes");
	a_vendor_ten: assert property (@(posedge sys_clk) disable iff (rst) // R4
		evt.cdb_first && evt.cdb_byte[7:5] == 3'h7 |-> rep_nxt.valid_group_flag ##1 cdb_len == 4'hA)
		else $error("group 7 not ten bytes");
	a_vgc_clear: assert property (@(posedge sys_clk) disable iff (rst) // R5
		serviced && !pend_v_r && !rep_nxt.valid_group_flag |=> !cur_r.valid_group_flag)
		else $error("valid-group flag survived service");
	a_init_needs_req: assert property (@(posedge sys_clk) disable iff (rst) // R7
		mode_r == sirq_pkg::SIRQ_INIT && !evt.req_seen |-> !rep_nxt.cause[sirq_pkg::C_BUS_SVC])
		else $error("initiator service without request");
	a_targ_attn: assert property (@(posedge sys_clk) disable iff (rst) // R15
		mode_r == sirq_pkg::SIRQ_TARG && evt.attn_seen |-> rep_nxt.cause[sirq_pkg::C_BUS_SVC])
		else $error("attention not reported");
	a_func_done: assert property (@(posedge sys_clk) disable iff (rst) // R16
		evt.cmd_done |-> rep_nxt.cause[sirq_pkg::C_FUNC])
		else $error("command end not reported");
	a_disc_cause: assert property (@(posedge sys_clk) disable iff (rst) // R14
		evt.target_disc |-> rep_nxt.cause[sirq_pkg::C_DISC])
		else $error("disconnect not reported");
	a_step_advance: assert property (@(posedge sys_clk) disable iff (rst) // R21
		evt.step_inc && !timeout_hit && !swrst_r && !serviced && !(new_ev && cur_v_r)
		|=> cur_r.step == $past(cur_r.step) + 3'h1)
		else $error("sequence step did not advance");
	a_queue_present: assert property (@(posedge sys_clk) disable iff (rst) // R24
		serviced && pend_v_r && !swrst_r |=> cur_v_r && cur_r == $past(pend_r))
		else $error("queued report not presented");
	a_bad_mode: assert property (@(posedge sys_clk) disable iff (rst) // R13
		evt.cmd_taken && evt.cmd_code[6:4] == 3'h2 && mode_r != sirq_pkg::SIRQ_TARG
		|-> bad_cmd)
		else $error("wrong-mode command accepted");
	a_sel_target: assert property (@(posedge sys_clk) disable iff (rst) // R17
		evt.sel_target && !evt.reselected && !sel_start && !swrst_r && !evt.target_disc
		&& !timeout_hit |=> mode_r == sirq_pkg::SIRQ_TARG)
		else $error("selection did not enter target mode");
endmodule : sirq_regs

// file: testbench/sirq_scsi_peer.sv
`timescale 1ns/1ps
// far side: drives the phase lines and the one-cycle event pulses of the bus core
module sirq_scsi_peer (
	input  wire logic           sys_clk,
	output logic [2:0]          bus_phase,
	output sirq_pkg::sirq_evt_t evt,
	output logic                arb_won,
	output logic                sel_start
);
	initial begin
		bus_phase = 3'h0;
		evt       = '0;
		arb_won   = 1'b0;
		sel_start = 1'b0;
	end

	// a target holds the phase lines steady until the bench moves them
	task automatic set_phase(input logic [2:0] p);
		@(posedge sys_clk);
		bus_phase <= p;
	endtask : set_phase

	// kind: 0 bus reset, 1 selected with first cdb byte, 2 selected with attention,
	// 3 reselected, 4 command code, 5 arbitration won, 6 select command,
	// 7 attention, 8 request, 9 request for message in, 10 step, 11 done, 12 disconnect
	task automatic fire(input int kind, input logic [7:0] b);
		sirq_pkg::sirq_evt_t e;
		e = '0;
		e.bus_rst = (kind == 0);
		e.sel_target = (kind == 1) || (kind == 2);
		e.cdb_first = (kind == 1);
		e.cdb_byte = b;
		e.sel_attn = (kind == 2);
		e.reselected = (kind == 3);
		e.cmd_taken = (kind == 4);
		e.cmd_code = b[6:0];
		e.attn_seen = (kind == 7);
		e.req_seen = (kind == 8) || (kind == 9);
		e.msg_in_req = (kind == 9);
		e.step_inc = (kind == 10);
		e.cmd_done = (kind == 11);
		e.target_disc = (kind == 12);
		@(posedge sys_clk);
		evt <= e;
		arb_won <= (kind == 5);
		sel_start <= (kind == 6);
		@(posedge sys_clk);
		evt <= '0;
		arb_won <= 1'b0;
		sel_start <= 1'b0;
	endtask : fire
endmodule : sirq_scsi_peer

// file: testbench/scsi_status_interrupt_regs_test.sv
`timescale 1ns/1ps
module scsi_status_interrupt_regs_test;
	logic                sys_clk = 1'b0;
	logic                rst;
	logic [3:0]          reg_addr;
	logic [7:0]          reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [7:0]          reg_rdata;
	logic [2:0]          bus_phase;
	sirq_pkg::sirq_evt_t evt;
	logic                arb_won;
	logic                sel_start;
	logic                irq;
	logic [7:0]          target_id_onehot;
	logic                sel_timed_out;
	logic [5:0]          sync_clks;
	logic                byte_tick;
	logic [3:0]          cdb_len;
	logic                chip_reset;
	int                  n_mismatch = 0;
	int                  check_count = 0;
	int                  cycles = 0;
	int                  i;
	logic [4:0]          codes [6] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h1f};
	logic [7:0]          clks  [6] = '{8'h20, 8'h23, 8'h05, 8'h05, 8'h06, 8'h1f};
	logic [2:0]          grp   [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2};
	logic [7:0]          lens  [9] = '{8'h06, 8'h0a, 8'h06, 8'h06, 8'h06, 8'h0c, 8'h06, 8'h0a, 8'h0a};
	logic                vgcs  [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

	sirq_regs sirq_regs_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.bus_phase(bus_phase), .evt(evt), .arb_won(arb_won), .sel_start(sel_start),
		.irq(irq), .target_id_onehot(target_id_onehot), .sel_timed_out(sel_timed_out),
		.sync_clks(sync_clks), .byte_tick(byte_tick), .cdb_len(cdb_len),
		.chip_reset(chip_reset));
	sirq_scsi_peer sirq_scsi_peer_inst (.sys_clk(sys_clk), .bus_phase(bus_phase), .evt(evt),
		.arb_won(arb_won), .sel_start(sel_start));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	// the whole run needs about 9000 cycles; well beyond that something hangs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rc(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rc

	task automatic wait_irq();
		for (int k = 0; k < 20 && irq !== 1'b1; k++) settle(1);
		chk({7'h00, irq}, 8'h01);
	endtask : wait_irq

	task automatic hw_reset();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
	endtask : hw_reset

	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		settle(1);
		chk({2'b00, sync_clks}, 8'h05);
		chk({4'h0, cdb_len}, 8'h06);
		rc(sirq_pkg::ADDR_CAUSE, 8'h00);
		sirq_scsi_peer_inst.set_phase(3'h6);
		rc(sirq_pkg::ADDR_STATUS, 8'h06);
		sirq_scsi_peer_inst.set_phase(3'h3);
		rc(sirq_pkg::ADDR_STATUS, 8'h03);
		$display("test reset and phase done");

		for (i = 0; i < 6; i++) begin
			wr(sirq_pkg::ADDR_SYNC_PER, {3'h7, codes[i]});
			settle(3);
			chk({2'b00, sync_clks}, clks[i]);
		end
		for (i = 0; i < 40 && byte_tick !== 1'b1; i++) settle(1);
		settle(1);
		for (i = 1; i < 40 && byte_tick !== 1'b1; i++) settle(1);
		chk(i[7:0], 8'h1f);
		wr(sirq_pkg::ADDR_DEST_ID, 8'hf7);
		settle(3);
		chk(target_id_onehot, 8'h80);
		wr(sirq_pkg::ADDR_DEST_ID, 8'h03);
		hw_reset();
		settle(3);
		chk(target_id_onehot, 8'h08);
		chk({2'b00, sync_clks}, 8'h05);
		$display("test sync period and target id done");

		wr(sirq_pkg::ADDR_SYNC_PER, 8'h06);
		sirq_scsi_peer_inst.fire(0, 8'h00);
		wait_irq();
		// a second report arrives while the first is still up
		sirq_scsi_peer_inst.fire(4, 8'h10);
		rc(sirq_pkg::ADDR_CAUSE, 8'h80);
		wait_irq();
		rc(sirq_pkg::ADDR_CAUSE, 8'h40);
		settle(2);
		chk({7'h00, irq}, 8'h00);
		chk({2'b00, sync_clks}, 8'h06);
		sirq_scsi_peer_inst.fire(4, 8'h07);
		settle(6);
		chk({7'h00, irq}, 8'h00);
		$display("test bus reset, bad command and queue done");

		sirq_scsi_peer_inst.set_phase(3'h0);
		for (i = 0; i < 9; i++) begin
			hw_reset();
			wr(sirq_pkg::ADDR_CTRL, (i == 8) ? 8'h01 : 8'h00);
			sirq_scsi_peer_inst.fire(1, {grp[i], 5'h00});
			wait_irq();
			chk({4'h0, cdb_len}, lens[i]);
			rc(sirq_pkg::ADDR_STATUS, {1'b1, 3'h0, vgcs[i], 3'h0});
			rc(sirq_pkg::ADDR_CAUSE, 8'h01);
			rc(sirq_pkg::ADDR_STATUS, 8'h00);
		end
		for (i = 2; i < 4; i++) begin
			hw_reset();
			sirq_scsi_peer_inst.fire(i, 8'h00);
			wait_irq();
			rc(sirq_pkg::ADDR_CAUSE, (i == 2) ? 8'h02 : 8'h04);
		end
		$display("test selection and group decode done");

		hw_reset();
		wr(sirq_pkg::ADDR_TIMEOUT, 8'h01);
		sirq_scsi_peer_inst.fire(6, 8'h00);
		sirq_scsi_peer_inst.fire(5, 8'h00);
		for (i = 0; i < 9000 && sel_timed_out !== 1'b1; i++) settle(1);
		chk((i > 8185 && i < 8195) ? 8'h01 : 8'h00, 8'h01);
		wait_irq();
		rc(sirq_pkg::ADDR_SEQ_STEP, 8'h00);
		rc(sirq_pkg::ADDR_CAUSE, 8'h20);
		$display("test selection timeout done");

		hw_reset();
		sirq_scsi_peer_inst.fire(2, 8'h00);
		wait_irq();
		rc(sirq_pkg::ADDR_CAUSE, 8'h02);
		sirq_scsi_peer_inst.fire(10, 8'h00);
		sirq_scsi_peer_inst.fire(7, 8'h00);
		wait_irq();
		rc(sirq_pkg::ADDR_SEQ_STEP, 8'h01);
		rc(sirq_pkg::ADDR_CAUSE, 8'h10);
		sirq_scsi_peer_inst.fire(11, 8'h00);
		wait_irq();
		rc(sirq_pkg::ADDR_CAUSE, 8'h08);
		sirq_scsi_peer_inst.fire(6, 8'h00);
		sirq_scsi_peer_inst.set_phase(3'h7);
		settle(4);
		chk({7'h00, irq}, 8'h00);
		sirq_scsi_peer_inst.fire(8, 8'h00);
		wait_irq();
		rc(sirq_pkg::ADDR_CAUSE, 8'h10);
		sirq_scsi_peer_inst.fire(9, 8'h00);
		wait_irq();
		rc(sirq_pkg::ADDR_STATUS, 8'h87);
		rc(sirq_pkg::ADDR_CAUSE, 8'h18);
		sirq_scsi_peer_inst.fire(12, 8'h00);
		wait_irq();
		rc(sirq_pkg::ADDR_CAUSE, 8'h20);
		$display("test bus service, function done and step done");

		sirq_scsi_peer_inst.fire(0, 8'h00);
		wait_irq();
		wr(sirq_pkg::ADDR_SYNC_PER, 8'h06);
		wr(sirq_pkg::ADDR_CTRL, 8'h02);
		for (i = 0; i < 10 && chip_reset !== 1'b1; i++) settle(1);
		chk({7'h00, chip_reset}, 8'h01);
		settle(3);
		chk({7'h00, irq}, 8'h00);
		chk({2'b00, sync_clks}, 8'h05);
		rc(sirq_pkg::ADDR_CAUSE, 8'h00);
		$display("test software reset done");
		test_done();
	end
endmodule : scsi_status_interrupt_regs_test
